// ==== alert_mask_pkg.sv ====
// Contract
// - Safety mask C AND word sets safety summary.
// - Safety mask C resets F4, reserved bits ignored.
// - Fail mask A match sets fail summary; 5F.
// - Fail mask B match sets fail summary; 9F.
// - Fail mask C match sets fail summary; 00.
// - Fail mask D bit 0 only sets summary.
// - Fail enable A resets 00, per-bit enables.
// - Fail enable B resets zero, per-bit enables.
// - Fail enable C resets 07, per-bit enables.
// - Enable bit 0 disables, 1 enables check.
// - Safety summary at bit 12, mask default 1.
// - Fail alert summary at bit 11, default 1.
// - Enabled permanent fail sets bit 13.
package alert_mask_pkg;

	localparam int unsigned ADDR_W  = 8;
	localparam int unsigned DATA_W  = 32;
	localparam int unsigned CFG_N   = 8;
	localparam int unsigned GATE_N  = 5;
	localparam int unsigned ALARM_W = 16;

	// Byte offsets on the register bus
	localparam logic [ADDR_W-1:0] OFF_SF_MASK_C  = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_PF_MASK_A  = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_PF_MASK_B  = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_PF_MASK_C  = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_PF_MASK_D  = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_PF_EN_A    = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_PF_EN_B    = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_PF_EN_C    = 8'h1C;
	localparam logic [ADDR_W-1:0] OFF_ALARM_RAW  = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK   = 8'h28;
	localparam logic [ADDR_W-1:0] CFG_SPAN       = 8'h20;

	// Config bytes in offset order: five alert masks, three fail enables
	localparam logic [7:0] CFG_RESET [CFG_N] = '{
		8'hF4, 8'h5F, 8'h9F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07
	};
	localparam logic [7:0] CFG_VALID [CFG_N] = '{
		8'hF4, 8'hDF, 8'h9F, 8'h78, 8'h01, 8'hDF, 8'h9F, 8'hFF
	};
	localparam int unsigned CFG_EN_BASE = 5;

	// Fail enable bit positions, byte A
	localparam int unsigned POS_COPPER_DEP   = 7;
	localparam int unsigned POS_FET_OVERTEMP = 6;
	localparam int unsigned POS_OVERTEMP     = 4;
	localparam int unsigned POS_DSG_OC       = 3;
	localparam int unsigned POS_CHG_OC       = 2;
	localparam int unsigned POS_CELL_OV      = 1;
	localparam int unsigned POS_CELL_UV      = 0;
	// Fail enable bit positions, byte B
	localparam int unsigned POS_SC_LATCH     = 7;
	localparam int unsigned POS_ACT_IMB      = 4;
	localparam int unsigned POS_REST_IMB     = 3;
	localparam int unsigned POS_SECOND_PROT  = 2;
	localparam int unsigned POS_DSG_SW       = 1;
	localparam int unsigned POS_CHG_SW       = 0;
	// Fail enable bit positions, byte C
	localparam int unsigned POS_COMMANDED    = 7;
	localparam int unsigned POS_STUCK_MUX    = 6;
	localparam int unsigned POS_GND_MEAS     = 5;
	localparam int unsigned POS_INT_REF      = 4;
	localparam int unsigned POS_SLOW_OSC     = 3;
	localparam int unsigned POS_INSTR_MEM    = 2;
	localparam int unsigned POS_DATA_MEM     = 1;
	localparam int unsigned POS_ONE_TIME_MEM = 0;

	// Alarm word bit positions
	localparam int unsigned BIT_PF_ALERT = 11;
	localparam int unsigned BIT_SF_ALERT = 12;
	localparam int unsigned BIT_PF_TRIP  = 13;
	localparam logic [ALARM_W-1:0] ALARM_IMPL      = 16'h3800;
	localparam logic [ALARM_W-1:0] IRQ_MASK_RESET  = 16'h3800;

	typedef struct packed {
		logic [7:0] safety_alert_word_c;
		logic [7:0] fail_alert_word_a;
		logic [7:0] fail_alert_word_b;
		logic [7:0] fail_alert_word_c;
		logic [7:0] fail_alert_word_d;
	} alert_words_type;

	typedef struct packed {
		logic [7:0] fail_a;
		logic [7:0] fail_b;
		logic [7:0] fail_c;
	} fail_faults_type;

endpackage : alert_mask_pkg

// ==== alert_gate.sv ====
`timescale 1ns/100ps
module alert_gate
	import alert_mask_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Mask and alert word
	input  wire logic [7:0] mask_i,
	input  wire logic [7:0] valid_i,
	input  wire logic [7:0] word_i,
	// Registered match
	output logic            hit_o
);

	logic hit_nxt;

	assign hit_nxt = |(mask_i & valid_i & word_i);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			hit_o <= 1'b0;
		else
			hit_o <= hit_nxt;
	end

endmodule : alert_gate

// ==== protection_alert_masking.sv ====
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
module protection_alert_masking
	import alert_mask_pkg::*;
(
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// Wishbone classic slave
	input  wire logic                cyc_i,
	input  wire logic                stb_i,
	input  wire logic                we_i,
	input  wire logic [3:0]          sel_i,
	input  wire logic [ADDR_W-1:0]   adr_i,
	input  wire logic [DATA_W-1:0]   dat_i,
	output logic      [DATA_W-1:0]   dat_o,
	output logic                     ack_o,
	// Alert and fault inputs from the detectors
	input  wire alert_words_type     alert_words_i,
	input  wire fail_faults_type     fail_faults_i,
	// Alarm and fail results
	output logic      [ALARM_W-1:0]  alarm_raw_word_o,
	output fail_faults_type          fail_trip_o,
	output logic                     irq_o
);

	function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		addr_is = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
	endfunction : addr_is

	// Bus decode
	logic                 req;
	logic                 wr_now;
	logic                 cfg_sel;
	logic [2:0]           cfg_idx;
	logic                 sel_raw;
	logic                 sel_stat;
	logic                 sel_mask;
	logic                 ack_r;
	logic [DATA_W-1:0]    dat_r;
	logic [DATA_W-1:0]    rd_data;

	// Configuration bytes
	logic [7:0]           cfg_r [CFG_N];
	logic [7:0]           word_arr [GATE_N];
	logic [GATE_N-1:0]    gate_hit;

	// Fail trips and summary flags
	fail_faults_type      trip_r;
	fail_faults_type      trip_nxt;
	logic                 masked_safety_alert_flag;
	logic                 masked_fail_alert_flag;
	logic                 fail_trip_flag;

	// Enable byte A checks
	logic                 copper_deposition_fail_en;
	logic                 fet_overtemp_fail_en;
	logic                 overtemp_fail_en;
	logic                 discharge_overcurrent_fail_en;
	logic                 charge_overcurrent_fail_en;
	logic                 cell_overvoltage_fail_en;
	logic                 cell_undervoltage_fail_en;
	logic [7:0]           enable_a_vec;

	// Enable byte B checks
	logic                 short_circuit_latch_fail_en;
	logic                 active_imbalance_fail_en;
	logic                 rest_imbalance_fail_en;
	logic                 second_protector_fail_en;
	logic                 discharge_switch_fail_en;
	logic                 charge_switch_fail_en;
	logic [7:0]           enable_b_vec;

	// Enable byte C checks
	logic                 commanded_fail_en;
	logic                 stuck_mux_fail_en;
	logic                 ground_measure_fail_en;
	logic                 internal_reference_fail_en;
	logic                 slow_oscillator_fail_en;
	logic                 instruction_memory_fail_en;
	logic                 data_memory_fail_en;
	logic                 one_time_memory_fail_en;
	logic [7:0]           enable_c_vec;

	// Alarm word and interrupt
	logic [ALARM_W-1:0]   alarm_raw_word;
	logic [ALARM_W-1:0]   alarm_prev_r;
	logic [ALARM_W-1:0]   alarm_rise;
	logic [ALARM_W-1:0]   irq_stat_r;
	logic [ALARM_W-1:0]   irq_stat_nxt;
	logic [ALARM_W-1:0]   irq_clr;
	logic [ALARM_W-1:0]   irq_mask_r;
	logic [ALARM_W-1:0]   irq_mask_nxt;
	logic [ALARM_W-1:0]   wr_lo16;

	// Request is taken on the first edge; write lands on the acked edge
	assign req      = cyc_i & stb_i;
	assign wr_now   = req & we_i & ack_r;
	assign cfg_sel  = (adr_i < CFG_SPAN);
	assign cfg_idx  = adr_i[4:2];
	assign sel_raw  = addr_is(adr_i, OFF_ALARM_RAW);
	assign sel_stat = addr_is(adr_i, OFF_IRQ_STATUS);
	assign sel_mask = addr_is(adr_i, OFF_IRQ_MASK);
	assign wr_lo16  = {sel_i[1] ? dat_i[15:8] : 8'h00, sel_i[0] ? dat_i[7:0] : 8'h00};

	assign ack_o = ack_r;
	assign dat_o = dat_r;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_r <= 1'b0;
		else
			ack_r <= req & ~ack_r;
	end

	// Read mux; unmapped offsets read as zero
	always_comb
	begin
		rd_data = '0;
		if (cfg_sel)
			rd_data = {24'h00_0000, cfg_r[cfg_idx] & CFG_VALID[cfg_idx]};
		else if (sel_raw)
			rd_data = {16'h0000, alarm_raw_word};
		else if (sel_stat)
			rd_data = {16'h0000, irq_stat_r};
		else if (sel_mask)
			rd_data = {16'h0000, irq_mask_r};
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_r <= '0;
		else if (req & ~ack_r & ~we_i)
			dat_r <= rd_data;
	end

	// Configuration bytes with their reset values
	generate
		for (genvar i = 0; i < CFG_N; i++)
		begin : g_cfg
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					cfg_r[i] <= CFG_RESET[i];
				else if (wr_now & cfg_sel & sel_i[0] & (cfg_idx == 3'(i)))
					cfg_r[i] <= dat_i[7:0];
			end
		end
	endgenerate

	// Alert words in the same order as the mask bytes
	assign word_arr[0] = alert_words_i.safety_alert_word_c;
	assign word_arr[1] = alert_words_i.fail_alert_word_a;
	assign word_arr[2] = alert_words_i.fail_alert_word_b;
	assign word_arr[3] = alert_words_i.fail_alert_word_c;
	assign word_arr[4] = alert_words_i.fail_alert_word_d;

	// Reserved mask bits are stripped by the valid pattern
	generate
		for (genvar g = 0; g < GATE_N; g++)
		begin : g_gate
			alert_gate u_gate (
				.clk_i   (clk_i),
				.rst_i   (rst_i),
				.mask_i  (cfg_r[g]),
				.valid_i (CFG_VALID[g]),
				.word_i  (word_arr[g]),
				.hit_o   (gate_hit[g])
			);
		end
	endgenerate

	assign masked_safety_alert_flag = gate_hit[0];
	assign masked_fail_alert_flag   = gate_hit[1]
		| gate_hit[2]
		| gate_hit[3]
		| gate_hit[4];

	// Byte A: one enable bit per check
	assign copper_deposition_fail_en     = cfg_r[CFG_EN_BASE][POS_COPPER_DEP];
	assign fet_overtemp_fail_en          = cfg_r[CFG_EN_BASE][POS_FET_OVERTEMP];
	assign overtemp_fail_en              = cfg_r[CFG_EN_BASE][POS_OVERTEMP];
	assign discharge_overcurrent_fail_en = cfg_r[CFG_EN_BASE][POS_DSG_OC];
	assign charge_overcurrent_fail_en    = cfg_r[CFG_EN_BASE][POS_CHG_OC];
	assign cell_overvoltage_fail_en      = cfg_r[CFG_EN_BASE][POS_CELL_OV];
	assign cell_undervoltage_fail_en     = cfg_r[CFG_EN_BASE][POS_CELL_UV];

	// Byte B: one enable bit per check
	assign short_circuit_latch_fail_en   = cfg_r[CFG_EN_BASE + 1][POS_SC_LATCH];
	assign active_imbalance_fail_en      = cfg_r[CFG_EN_BASE + 1][POS_ACT_IMB];
	assign rest_imbalance_fail_en        = cfg_r[CFG_EN_BASE + 1][POS_REST_IMB];
	assign second_protector_fail_en      = cfg_r[CFG_EN_BASE + 1][POS_SECOND_PROT];
	assign discharge_switch_fail_en      = cfg_r[CFG_EN_BASE + 1][POS_DSG_SW];
	assign charge_switch_fail_en         = cfg_r[CFG_EN_BASE + 1][POS_CHG_SW];

	// Byte C: one enable bit per check
	assign commanded_fail_en             = cfg_r[CFG_EN_BASE + 2][POS_COMMANDED];
	assign stuck_mux_fail_en             = cfg_r[CFG_EN_BASE + 2][POS_STUCK_MUX];
	assign ground_measure_fail_en        = cfg_r[CFG_EN_BASE + 2][POS_GND_MEAS];
	assign internal_reference_fail_en    = cfg_r[CFG_EN_BASE + 2][POS_INT_REF];
	assign slow_oscillator_fail_en       = cfg_r[CFG_EN_BASE + 2][POS_SLOW_OSC];
	assign instruction_memory_fail_en    = cfg_r[CFG_EN_BASE + 2][POS_INSTR_MEM];
	assign data_memory_fail_en           = cfg_r[CFG_EN_BASE + 2][POS_DATA_MEM];
	assign one_time_memory_fail_en       = cfg_r[CFG_EN_BASE + 2][POS_ONE_TIME_MEM];

	// Byte A enable vector; reserved positions stay low
	always_comb
	begin
		enable_a_vec                   = 8'h00;
		enable_a_vec[POS_COPPER_DEP]   = copper_deposition_fail_en;
		enable_a_vec[POS_FET_OVERTEMP] = fet_overtemp_fail_en;
		enable_a_vec[POS_OVERTEMP]     = overtemp_fail_en;
		enable_a_vec[POS_DSG_OC]       = discharge_overcurrent_fail_en;
		enable_a_vec[POS_CHG_OC]       = charge_overcurrent_fail_en;
		enable_a_vec[POS_CELL_OV]      = cell_overvoltage_fail_en;
		enable_a_vec[POS_CELL_UV]      = cell_undervoltage_fail_en;
	end

	// Byte B enable vector; reserved positions stay low
	always_comb
	begin
		enable_b_vec                   = 8'h00;
		enable_b_vec[POS_SC_LATCH]     = short_circuit_latch_fail_en;
		enable_b_vec[POS_ACT_IMB]      = active_imbalance_fail_en;
		enable_b_vec[POS_REST_IMB]     = rest_imbalance_fail_en;
		enable_b_vec[POS_SECOND_PROT]  = second_protector_fail_en;
		enable_b_vec[POS_DSG_SW]       = discharge_switch_fail_en;
		enable_b_vec[POS_CHG_SW]       = charge_switch_fail_en;
	end

	// Byte C enable vector; every position is a check
	always_comb
	begin
		enable_c_vec                   = 8'h00;
		enable_c_vec[POS_COMMANDED]    = commanded_fail_en;
		enable_c_vec[POS_STUCK_MUX]    = stuck_mux_fail_en;
		enable_c_vec[POS_GND_MEAS]     = ground_measure_fail_en;
		enable_c_vec[POS_INT_REF]      = internal_reference_fail_en;
		enable_c_vec[POS_SLOW_OSC]     = slow_oscillator_fail_en;
		enable_c_vec[POS_INSTR_MEM]    = instruction_memory_fail_en;
		enable_c_vec[POS_DATA_MEM]     = data_memory_fail_en;
		enable_c_vec[POS_ONE_TIME_MEM] = one_time_memory_fail_en;
	end

	// A fault passes only where its enable bit is one
	assign trip_nxt.fail_a = fail_faults_i.fail_a & enable_a_vec;
	assign trip_nxt.fail_b = fail_faults_i.fail_b & enable_b_vec;
	assign trip_nxt.fail_c = fail_faults_i.fail_c & enable_c_vec;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			trip_r <= '0;
		else
			trip_r <= trip_nxt;
	end

	assign fail_trip_flag = |trip_r;
	assign fail_trip_o    = trip_r;

	// Only the summary bits of the alarm word live in this block
	always_comb
	begin
		alarm_raw_word               = '0;
		alarm_raw_word[BIT_SF_ALERT] = masked_safety_alert_flag;
		alarm_raw_word[BIT_PF_ALERT] = masked_fail_alert_flag;
		alarm_raw_word[BIT_PF_TRIP]  = fail_trip_flag;
	end

	assign alarm_raw_word_o = alarm_raw_word;

	// Sticky interrupt status on each rising summary bit
	assign alarm_rise   = alarm_raw_word & ~alarm_prev_r;
	assign irq_clr      = (wr_now & sel_stat) ? wr_lo16 : '0;
	assign irq_stat_nxt = ((irq_stat_r & ~irq_clr) | alarm_rise) & ALARM_IMPL;
	assign irq_mask_nxt = (wr_now & sel_mask) ? (wr_lo16 & ALARM_IMPL) : irq_mask_r;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			alarm_prev_r <= '0;
		else
			alarm_prev_r <= alarm_raw_word;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_stat_r <= '0;
		else
			irq_stat_r <= irq_stat_nxt;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_mask_r <= IRQ_MASK_RESET;
		else
			irq_mask_r <= irq_mask_nxt;
	end

	assign irq_o = |(irq_stat_r & irq_mask_r);

endmodule : protection_alert_masking

// ==== alert_mask_asserts.sv ====
`timescale 1ns/100ps
module alert_mask_asserts
	import alert_mask_pkg::*;
(
	// Clock, reset and bus
	input wire logic               clk_i,
	input wire logic               rst_i,
	input wire logic               cyc_i,
	input wire logic               stb_i,
	input wire logic               ack_o,
	// Alert path
	input wire alert_words_type    alert_words_i,
	input wire fail_faults_type    fail_faults_i,
	input wire logic [ALARM_W-1:0] alarm_raw_word_o,
	input wire fail_faults_type    fail_trip_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_sf;
		alarm_raw_word_o[12] |-> $past(|(alert_words_i[39:32] & 8'hF4));
	endproperty
	property p_pf;
		alarm_raw_word_o[11] |-> $past(|(alert_words_i[31:0] & 32'hDF9F_7801));
	endproperty
	property p_tr;
		(fail_trip_o & ~$past(fail_faults_i & 24'hDF_9FFF)) == 24'h00_0000;
	endproperty
	property p_pt;
		alarm_raw_word_o[13] == |fail_trip_o;
	endproperty
	property p_rs;
		(alarm_raw_word_o & 16'hC7FF) == 16'h0000;
	endproperty
	property p_ak;
		cyc_i && stb_i && !ack_o |=> ack_o;
	endproperty
	property p_pl;
		ack_o |=> !ack_o;
	endproperty
	property p_cs;
		ack_o |-> $past(cyc_i && stb_i);
	endproperty
	a_sf: assert property (p_sf) else $error("safety summary without cause");
	a_pf: assert property (p_pf) else $error("fail summary without cause");
	a_tr: assert property (p_tr) else $error("trip without fault");
	a_pt: assert property (p_pt) else $error("trip flag mismatch");
	a_rs: assert property (p_rs) else $error("stray alarm bit");
	a_ak: assert property (p_ak) else $error("late ack");
	a_pl: assert property (p_pl) else $error("ack too long");
	a_cs: assert property (p_cs) else $error("ack without request");
	c_sf: cover property (alarm_raw_word_o[12]);
	c_pf: cover property (alarm_raw_word_o[11]);
	c_pt: cover property (alarm_raw_word_o[13]);
endmodule : alert_mask_asserts
bind protection_alert_masking alert_mask_asserts chk_u (.clk_i, .rst_i, .cyc_i, .stb_i,
	.ack_o, .alert_words_i, .fail_faults_i, .alarm_raw_word_o, .fail_trip_o);

// ==== test_protection_alert_masking.sv ====
`timescale 1ns/100ps
module test_protection_alert_masking
	import alert_mask_pkg::*;
;
	logic            clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, irq_o;
	logic [3:0]      sel_i = 4'hF;
	logic [7:0]      adr_i = 8'h00;
	logic [31:0]     dat_i = '0, dat_o, rdat;
	alert_words_type alert_words_i = '0;
	fail_faults_type fail_faults_i = '0, fail_trip_o;
	logic [15:0]     alarm_raw_word_o;
	int              num_errors = 0, comparisons = 0;
	protection_alert_masking dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .sel_i, .adr_i,
		.dat_i, .dat_o, .ack_o, .alert_words_i, .fail_faults_i, .alarm_raw_word_o,
		.fail_trip_o, .irq_o);
	always #50 clk_i = ~clk_i;
	task ck(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : ck
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		@(posedge clk_i);
		while (ack_o !== 1'b1)
			@(posedge clk_i);
		rdat = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task t_regs;
		for (int i = 0; i < CFG_N; i++)
		begin
			wb(1'b0, 8'(4 * i), '0);
			ck(rdat, CFG_RESET[i]);
			wb(1'b1, 8'(4 * i), 32'hFFFF_FFFF);
			wb(1'b0, 8'(4 * i), '0);
			ck(rdat, CFG_VALID[i]);
		end
		wb(1'b0, OFF_IRQ_MASK, '0);
		ck(rdat, 32'h0000_3800);
		wb(1'b0, 8'h40, '0);
		ck(rdat, '0);
	endtask : t_regs
	task t_alerts;
		for (int i = 0; i < 5; i++)
		begin
			alert_words_i <= {32'h0000_0000, ~CFG_VALID[i]} << (32 - 8 * i);
			repeat (2) @(posedge clk_i);
			ck(alarm_raw_word_o, '0);
			alert_words_i <= {32'h0000_0000, CFG_VALID[i]} << (32 - 8 * i);
			repeat (2) @(posedge clk_i);
			ck(alarm_raw_word_o, i == 0 ? 16'h1000 : 16'h0800);
		end
		wb(1'b1, OFF_PF_MASK_D, '0);
		@(posedge clk_i);
		ck(alarm_raw_word_o, '0);
	endtask : t_alerts
	task t_trip;
		fail_faults_i <= 24'hFF_FFFF;
		repeat (2) @(posedge clk_i);
		ck(fail_trip_o, 32'h00DF_9FFF);
		ck(alarm_raw_word_o, 16'h2000);
		wb(1'b1, OFF_PF_EN_C, '0);
		@(posedge clk_i);
		ck(fail_trip_o, 32'h00DF_9F00);
	endtask : t_trip
	task t_irq;
		ck(irq_o, 1'b1);
		fail_faults_i <= '0;
		alert_words_i <= '0;
		wb(1'b1, OFF_IRQ_STATUS, 32'h0000_3800);
		@(posedge clk_i);
		ck(irq_o, 1'b0);
		wb(1'b1, OFF_IRQ_MASK, 32'h0000_1000);
		alert_words_i <= 40'h00_0100_0000;
		repeat (4) @(posedge clk_i);
		ck(irq_o, 1'b0);
		wb(1'b0, OFF_IRQ_STATUS, '0);
		ck(rdat, 32'h0000_0800);
		alert_words_i <= 40'h04_0100_0000;
		repeat (4) @(posedge clk_i);
		ck(irq_o, 1'b1);
	endtask : t_irq
	task give_verdict;
		if (num_errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict
	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_regs;
		t_alerts;
		t_trip;
		t_irq;
		give_verdict;
	end
	initial
	begin
		repeat (2000) @(posedge clk_i);
		num_errors++;
		give_verdict;
	end
endmodule : test_protection_alert_masking
